// file: logic/aea_energy_accumulator.sv
module aea_energy_accumulator
    import aea_pkg::*;
#(
    parameter int PULSE_THRESHOLD = 1 << 22,
    parameter int PULSE_WIDTH = 4
) (
    input wire logic pclk, // Clock, 50 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire aea_meas_s meas, // Power, voltage sign and no-load level.
    output logic meter_irq, // Pending interrupt, active high.
    output logic frequency_pulse_out_n, // Energy pulse, active low.
    output logic signed [POWER_W-1:0] wave_data, // Waveform sample.
    output logic wave_valid // One-cycle strobe with a new sample.
);
    typedef enum logic [0:0] {LC_WAIT, LC_RUN} aea_lc_e;

    logic [7:0] mode_r;
    logic [15:0] half_cycle_count_r;
    logic [7:0] energy_divider_r;
    logic [11:0] power_gain_r;
    logic [7:0] wave_select_r;
    logic [7:0] irq_en_mid_r;
    logic [7:0] irq_en_high_r;
    logic [7:0] irq_st_mid_r;
    logic [7:0] irq_st_high_r;
    logic [2:0] step_cnt_r;
    logic step;
    logic signed [ACC_W-1:0] acc_r;
    logic signed [ACC_W-1:0] acc_base;
    logic signed [ACC_W-1:0] acc_nxt;
    logic signed [ACC_W-1:0] lc_acc_r;
    logic [VIS_W-1:0] line_energy_r;
    logic [15:0] lc_cnt_r;
    aea_lc_e lc_state_r;
    logic volt_pos_r;
    logic zero_cross;
    logic lc_end;
    logic signed [POWER_W+13:0] gained;
    logic signed [POWER_W+13:0] divided;
    logic signed [POWER_W+13:0] mode_val;
    logic signed [ACC_W-1:0] step_val;
    logic signed [31:0] pulse_acc_r;
    logic [7:0] pulse_cnt_r;
    logic [11:0] wave_cnt_r;
    logic [2:0] wave_pre_r;
    logic [7:0] idx;
    logic mapped;
    logic wr_done;
    logic rd_done;
    logic hcc_write;
    logic cor_read;
    logic half_evt;
    logic ovf_evt;
    logic unf_evt;
    logic [31:0] rd_val;

    assign idx = paddr[9:2];
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_done = psel && penable && pready && !pwrite;
    assign hcc_write = wr_done && idx == IDX_HALF_CYCLE_COUNT;
    assign cor_read = rd_done && idx == IDX_ENERGY_TOTAL_CLEAR_ON_READ && !pslverr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_r <= '0;
        end else if (step_cnt_r == 3'(ACC_STEP_CYCLES - 1)) begin
            step_cnt_r <= '0;
        end else begin
            step_cnt_r <= step_cnt_r + 3'h1;
        end
    end
    assign step = step_cnt_r == 3'(ACC_STEP_CYCLES - 1);

    always_comb begin
        gained = (38'(meas.power) * 38'(signed'({1'b0, 13'h1000}) + 38'(signed'(power_gain_r))))
            >>> GAIN_SHIFT;
        // Division truncates toward zero.
        // divider, zero as one
        divided = gained / 38'(signed'({1'b0, (energy_divider_r == 8'h00) ? 8'h01
            : energy_divider_r}));
        if (mode_r[POSITIVE_ONLY_SELECT_BIT]) begin
            mode_val = (divided > 0) ? divided : '0;
        end else if (mode_r[ABSOLUTE_SELECT_BIT]) begin
            mode_val = (divided < 0) ? -divided : divided;
        end else begin
            mode_val = divided;
        end
        step_val = meas.no_load ? '0 : ACC_W'(mode_val);
    end

    // A clear-on-read and a step in one cycle: the clear applies first, then the step adds.
    // accumulator update
    always_comb begin
        acc_base = acc_r;
        if (cor_read) begin
            acc_base[ACC_W-1 -: VIS_W] = '0;
        end
        acc_nxt = step ? acc_base + step_val : acc_base;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Overflow and underflow are sign flips of the accumulator in the direction of the step.
    // energy events
    assign ovf_evt = step && !acc_base[ACC_W-1] && acc_nxt[ACC_W-1] && step_val > 0;
    assign unf_evt = step && acc_base[ACC_W-1] && !acc_nxt[ACC_W-1] && step_val < 0;
    assign half_evt = step && ((!acc_nxt[ACC_W-1] && acc_nxt[ACC_W-2] && !acc_base[ACC_W-2])
        || (acc_nxt[ACC_W-1] && !acc_nxt[ACC_W-2] && acc_base[ACC_W-2] && acc_base[ACC_W-1]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volt_pos_r <= 1'b0;
        end else begin
            volt_pos_r <= meas.volt_positive;
        end
    end
    assign zero_cross = volt_pos_r != meas.volt_positive;
    // A count of zero ends each cycle at its first crossing.
    // 16-bit count target
    assign lc_end = lc_state_r == LC_RUN && zero_cross
        && (lc_cnt_r + 16'h1 >= half_cycle_count_r || half_cycle_count_r == 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_state_r <= LC_WAIT;
            lc_cnt_r <= '0;
            lc_acc_r <= '0;
            line_energy_r <= '0;
        end else if (hcc_write) begin
            lc_state_r <= LC_WAIT;
            lc_cnt_r <= '0;
            lc_acc_r <= '0;
            line_energy_r <= '0;
        end else begin
            unique case (lc_state_r)
                LC_WAIT: begin
                    if (zero_cross) begin
                        lc_state_r <= LC_RUN;
                        lc_cnt_r <= '0;
                        lc_acc_r <= '0;
                    end
                end
                LC_RUN: begin
                    if (lc_end) begin
                        line_energy_r <= lc_acc_r[ACC_W-1 -: VIS_W];
                        lc_cnt_r <= '0;
                        lc_acc_r <= step ? step_val : '0;
                    end else begin
                        if (zero_cross) begin
                            lc_cnt_r <= lc_cnt_r + 16'h1;
                        end
                        if (step) begin
                            lc_acc_r <= lc_acc_r + step_val;
                        end
                    end
                end
            endcase
        end
    end

    // Keep PULSE_THRESHOLD above the largest step so the residue stays within one threshold.
    // Otherwise a stored residue goes on pulsing after the power has stopped.
    // pulse output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_acc_r <= '0;
            pulse_cnt_r <= '0;
            frequency_pulse_out_n <= 1'b1;
        end else begin
            if (pulse_cnt_r != 8'h00) begin
                pulse_cnt_r <= pulse_cnt_r - 8'h1;
            end
            frequency_pulse_out_n <= !(pulse_cnt_r > 8'h1);
            if (step) begin
                if (pulse_acc_r + 32'(step_val) >= PULSE_THRESHOLD) begin
                    pulse_acc_r <= pulse_acc_r + 32'(step_val) - PULSE_THRESHOLD;
                    pulse_cnt_r <= 8'(PULSE_WIDTH + 1);
                end else if (pulse_acc_r + 32'(step_val) <= -PULSE_THRESHOLD) begin
                    pulse_acc_r <= pulse_acc_r + 32'(step_val) + PULSE_THRESHOLD;
                    pulse_cnt_r <= 8'(PULSE_WIDTH + 1);
                end else begin
                    pulse_acc_r <= pulse_acc_r + 32'(step_val);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_cnt_r <= '0;
            wave_pre_r <= '0;
            wave_data <= '0;
            wave_valid <= 1'b0;
        end else begin
            wave_valid <= 1'b0;
            if (wave_cnt_r == 12'(WAVE_BASE_CYCLES - 1)) begin
                wave_cnt_r <= '0;
                if (wave_pre_r >= ((3'h1 << wave_select_r[WAVE_RATE_LSB +: 2]) - 3'h1)) begin
                    wave_pre_r <= '0;
                    if (irq_en_high_r[WAVEFORM_SAMPLING_ENABLE_BIT]
                        && wave_select_r[1:0] == WAVE_SRC_ACTIVE_POWER) begin
                        wave_data <= POWER_W'(gained);
                        wave_valid <= 1'b1;
                    end
                end else begin
                    wave_pre_r <= wave_pre_r + 3'h1;
                end
            end else begin
                wave_cnt_r <= wave_cnt_r + 12'h1;
            end
        end
    end

    // Configuration registers.
    // Writes to read-only or unmapped indices fall to the default and are ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_CONTROL_RESET;
            half_cycle_count_r <= HALF_CYCLE_COUNT_RESET;
            energy_divider_r <= ENERGY_DIVIDER_RESET;
            power_gain_r <= POWER_GAIN_RESET;
            wave_select_r <= WAVE_SELECT_RESET;
            irq_en_mid_r <= IRQ_EN_RESET;
            irq_en_high_r <= IRQ_EN_RESET;
        end else if (wr_done) begin
            unique case (idx)
                IDX_ACCUMULATION_MODE_CONTROL: mode_r <= pwdata[7:0];
                IDX_HALF_CYCLE_COUNT: half_cycle_count_r <= pwdata[15:0];
                IDX_ENERGY_DIVIDER: energy_divider_r <= pwdata[7:0];
                IDX_POWER_GAIN: power_gain_r <= pwdata[11:0];
                IDX_WAVEFORM_SOURCE_SELECT: wave_select_r <= pwdata[7:0];
                IDX_INTERRUPT_ENABLE_MID: irq_en_mid_r <= pwdata[7:0];
                IDX_INTERRUPT_ENABLE_HIGH: irq_en_high_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_mid_r <= '0;
            irq_st_high_r <= '0;
        end else begin
            irq_st_mid_r <= (wr_done && idx == IDX_INTERRUPT_STATUS_MID)
                ? irq_st_mid_r & ~pwdata[7:0] : irq_st_mid_r;
            irq_st_high_r <= (wr_done && idx == IDX_INTERRUPT_STATUS_HIGH)
                ? irq_st_high_r & ~pwdata[7:0] : irq_st_high_r;
            if (half_evt) begin
                irq_st_mid_r[HALF_FULL_BIT] <= 1'b1;
            end
            if (ovf_evt) begin
                irq_st_mid_r[OVERFLOW_BIT] <= 1'b1;
            end
            if (unf_evt) begin
                irq_st_mid_r[UNDERFLOW_BIT] <= 1'b1;
            end
            if (lc_end && !hcc_write) begin
                irq_st_high_r[CYCLE_END_FLAG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meter_irq <= 1'b0;
        end else begin
            meter_irq <= |(irq_st_mid_r & irq_en_mid_r)
                || |(irq_st_high_r & irq_en_high_r & HIGH_IRQ_MASK);
        end
    end

    always_comb begin
        mapped = 1'b1;
        rd_val = '0;
        unique case (idx)
            IDX_ENERGY_TOTAL: rd_val = 32'(acc_r[ACC_W-1 -: VIS_W]);
            IDX_ENERGY_TOTAL_CLEAR_ON_READ: rd_val = 32'(acc_r[ACC_W-1 -: VIS_W]);
            IDX_LINE_CYCLE_ENERGY: rd_val = 32'(line_energy_r);
            IDX_ACCUMULATION_MODE_CONTROL: rd_val = 32'(mode_r);
            IDX_HALF_CYCLE_COUNT: rd_val = 32'(half_cycle_count_r);
            IDX_ENERGY_DIVIDER: rd_val = 32'(energy_divider_r);
            IDX_POWER_GAIN: rd_val = 32'(power_gain_r);
            IDX_WAVEFORM_SOURCE_SELECT: rd_val = 32'(wave_select_r);
            IDX_WAVEFORM_DATA: rd_val = 32'(unsigned'(wave_data));
            IDX_INTERRUPT_STATUS_MID: rd_val = 32'(irq_st_mid_r);
            IDX_INTERRUPT_ENABLE_MID: rd_val = 32'(irq_en_mid_r);
            IDX_INTERRUPT_ENABLE_HIGH: rd_val = 32'(irq_en_high_r);
            IDX_INTERRUPT_STATUS_HIGH: rd_val = 32'(irq_st_high_r);
            default: mapped = 1'b0;
        endcase
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end
    end

    // Each access waits one cycle so read data and the answer come from flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= (!pwrite && mapped) ? rd_val : 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
    end
endmodule : aea_energy_accumulator

// file: logic/aea_pkg.sv
package aea_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_ENERGY_TOTAL = 8'h01;
    localparam logic [7:0] IDX_ENERGY_TOTAL_CLEAR_ON_READ = 8'h02;
    localparam logic [7:0] IDX_LINE_CYCLE_ENERGY = 8'h03;
    localparam logic [7:0] IDX_WAVEFORM_SOURCE_SELECT = 8'h0D;
    localparam logic [7:0] IDX_ACCUMULATION_MODE_CONTROL = 8'h0F;
    localparam logic [7:0] IDX_HALF_CYCLE_COUNT = 8'h12;
    localparam logic [7:0] IDX_POWER_GAIN = 8'h1D;
    localparam logic [7:0] IDX_ENERGY_DIVIDER = 8'h24;
    localparam logic [7:0] IDX_WAVEFORM_DATA = 8'h40;
    localparam logic [7:0] IDX_INTERRUPT_STATUS_MID = 8'h41;
    localparam logic [7:0] IDX_INTERRUPT_ENABLE_MID = 8'hDA;
    localparam logic [7:0] IDX_INTERRUPT_ENABLE_HIGH = 8'hDB;
    localparam logic [7:0] IDX_INTERRUPT_STATUS_HIGH = 8'hDE;
    // Field positions and the active-power source code.
    localparam int ABSOLUTE_SELECT_BIT = 0;
    localparam int POSITIVE_ONLY_SELECT_BIT = 1;
    localparam int CYCLE_END_FLAG_BIT = 2;
    localparam int WAVEFORM_SAMPLING_ENABLE_BIT = 5;
    localparam int HALF_FULL_BIT = 0;
    localparam int OVERFLOW_BIT = 1;
    localparam int UNDERFLOW_BIT = 2;
    localparam int WAVE_RATE_LSB = 3;
    localparam logic [1:0] WAVE_SRC_ACTIVE_POWER = 2'h0;
    // Reset values and the high interrupt mask.
    localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
    localparam logic [15:0] HALF_CYCLE_COUNT_RESET = 16'hFFFF;
    localparam logic [7:0] ENERGY_DIVIDER_RESET = 8'h00;
    localparam logic [11:0] POWER_GAIN_RESET = 12'h000;
    localparam logic [7:0] WAVE_SELECT_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] HIGH_IRQ_MASK = 8'h04;
    // Widths and timing.
    localparam int ACC_W = 49;
    localparam int VIS_W = 24;
    localparam int POWER_W = 24;
    localparam int GAIN_SHIFT = 12;
    localparam int CLK_HZ = 50_000_000;
    localparam int ACC_STEP_CYCLES = 5;
    localparam int WAVE_BASE_SPS = 25_600;
    localparam int WAVE_BASE_CYCLES = CLK_HZ / WAVE_BASE_SPS;

    typedef struct packed {
        logic signed [POWER_W-1:0] power;
        logic volt_positive;
        logic no_load;
    } aea_meas_s;
endpackage : aea_pkg

// file: test/aea_monitor.sv
module aea_monitor #(
    parameter int PULSE_WIDTH = 4
) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic [11:0] paddr, // Byte address.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic frequency_pulse_out_n, // Pulse, active low.
    input wire logic wave_valid // Sample strobe.
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    int low_cnt;

    // Counts the cycles the pulse output has been low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 0;
        end else if (frequency_pulse_out_n) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end

    sequence s_wait_state;
        !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_ready_timing: assert property (psel && $rose(penable) |-> s_wait_state ##1 s_answer)
        else $error("ready not in second access cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero while idle");
    a_bad_address: assert property (psel && penable && pready
        && (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) |-> pslverr)
        else $error("bad address not refused");
    a_pulse_width: assert property ($rose(frequency_pulse_out_n) |-> low_cnt == PULSE_WIDTH)
        else $error("pulse width wrong");
    a_pulse_bound: assert property (low_cnt <= PULSE_WIDTH)
        else $error("pulse too long");
    a_wave_spacing: assert property (wave_valid |=> (!wave_valid)[*8])
        else $error("wave strobes too close");
endmodule : aea_monitor

bind aea_energy_accumulator aea_monitor #(.PULSE_WIDTH(PULSE_WIDTH)) u_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frequency_pulse_out_n(frequency_pulse_out_n), .wave_valid(wave_valid)
);

// file: test/tb.sv
module tb
    import aea_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, meter_irq, pulse_n, wave_valid, err;
    logic signed [23:0] wave_data;
    aea_meas_s meas = '{24'h000000, 1'b0, 1'b1};
    int n_errors = 0, checks = 0, cyc = 0, pulses = 0;
    longint acc_m = 0, lc_m = 0;
    logic [7:0] mode_m = 8'h00, div_m = 8'h00;

    always #10 pclk = ~pclk;
    always @(negedge pulse_n) pulses++;

    aea_energy_accumulator #(.PULSE_THRESHOLD(1 << 24), .PULSE_WIDTH(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas(meas), .meter_irq(meter_irq), .frequency_pulse_out_n(pulse_n),
        .wave_data(wave_data), .wave_valid(wave_valid)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, {2'h0, idx, 2'h0}, d);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, {2'h0, idx, 2'h0}, 32'h0);
        chk(what, exp, rd);
    endtask : rdc

    // Opens the load gate for exactly k accumulation steps and updates the model.
    task automatic run(input logic signed [23:0] p, input int k);
        longint v;
        longint d;
        d = (div_m == 8'h00) ? 1 : div_m;
        v = longint'(p) / d;
        if (mode_m[POSITIVE_ONLY_SELECT_BIT]) begin
            v = (v > 0) ? v : 0;
        end else if (mode_m[ABSOLUTE_SELECT_BIT]) begin
            v = (v < 0) ? -v : v;
        end
        meas.power <= p;
        meas.no_load <= 1'b0;
        repeat (5 * k) @(posedge pclk);
        meas.no_load <= 1'b1;
        @(posedge pclk);
        acc_m += v * k;
        lc_m += v * k;
    endtask : run

    task automatic flip();
        meas.volt_positive <= ~meas.volt_positive;
        @(posedge pclk);
    endtask : flip

    task automatic s_regs();
        rdc("mode", IDX_ACCUMULATION_MODE_CONTROL, 32'h0);
        rdc("count", IDX_HALF_CYCLE_COUNT, 32'h0000FFFF);
        rdc("divider", IDX_ENERGY_DIVIDER, 32'h0);
        wr(IDX_HALF_CYCLE_COUNT, 32'h12345678);
        rdc("count width", IDX_HALF_CYCLE_COUNT, 32'h00005678);
        wr(IDX_ENERGY_DIVIDER, 32'h000001FF);
        rdc("divider width", IDX_ENERGY_DIVIDER, 32'h000000FF);
        wr(IDX_ENERGY_TOTAL, 32'h00000123);
        rdc("energy ro", IDX_ENERGY_TOTAL, 32'h0);
        apb(1'b0, 12'h402, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask : s_regs

    task automatic s_modes();
        for (int m = 0; m < 4; m++) begin
            mode_m = 8'(m);
            div_m = 8'(m);
            wr(IDX_ACCUMULATION_MODE_CONTROL, 32'(m));
            wr(IDX_ENERGY_DIVIDER, 32'(m));
            pulses = 0;
            run(-24'sh7FFFFF, 8);
            chk("pulses", (m < 2) ? 1 : 0, {31'h0, pulses > 0});
            run(24'sh7FFFFF, 16);
            rdc("energy", IDX_ENERGY_TOTAL_CLEAR_ON_READ, {8'h00, acc_m[48:25]});
            acc_m &= 64'h1FFFFFF;
            rdc("cleared", IDX_ENERGY_TOTAL, {8'h00, acc_m[48:25]});
        end
    endtask : s_modes

    task automatic s_line();
        mode_m = 8'h00;
        div_m = 8'h00;
        wr(IDX_ACCUMULATION_MODE_CONTROL, 32'h0);
        wr(IDX_ENERGY_DIVIDER, 32'h0);
        wr(IDX_INTERRUPT_ENABLE_HIGH, 32'h04);
        wr(IDX_HALF_CYCLE_COUNT, 32'h2);
        rdc("line cleared", IDX_LINE_CYCLE_ENERGY, 32'h0);
        flip();
        // The second cycle starts at the first cycle's end and overwrites its result.
        for (int c = 0; c < 2; c++) begin
            lc_m = 0;
            run(c ? 24'sh200000 : 24'sh600000, 8);
            flip();
            run(c ? 24'sh200000 : 24'sh600000, 8);
            flip();
        end
        rdc("line energy", IDX_LINE_CYCLE_ENERGY, {8'h00, lc_m[48:25]});
        rdc("cycle end", IDX_INTERRUPT_STATUS_HIGH, 32'h4);
        chk("irq set", 32'h1, {31'h0, meter_irq});
        wr(IDX_INTERRUPT_STATUS_HIGH, 32'h4);
        @(posedge pclk);
        chk("irq clear", 32'h0, {31'h0, meter_irq});
        wr(IDX_HALF_CYCLE_COUNT, 32'h2);
        rdc("line reset", IDX_LINE_CYCLE_ENERGY, 32'h0);
    endtask : s_line

    task automatic s_wave();
        wr(IDX_INTERRUPT_ENABLE_HIGH, 32'h20);
        meas.power <= 24'sh100000;
        for (int i = 0; i < 2; i++) begin
            wr(IDX_POWER_GAIN, i ? 32'h800 : 32'h7FF);
            for (int s = 0; s < 2; s++) begin
                do begin
                    @(posedge pclk);
                end while (wave_valid !== 1'b1);
            end
            chk("wave", i ? 32'h00080000 : 32'h0017FF00, {8'h00, wave_data});
        end
    endtask : s_wave

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_regs();
        s_modes();
        s_line();
        s_wave();
        close_out();
    end
endmodule : tb
